/* alr_defines.vh */
// Constants for the ambient light configuration and result register block
`ifndef ALR_DEFINES_VH
`define ALR_DEFINES_VH
// ****************************************************************
// Register addresses
// ****************************************************************
`define ALR_ADDR_PARAMS 8'h84
`define ALR_ADDR_RES_HI 8'h85
`define ALR_ADDR_RES_LO 8'h86
// ****************************************************************
// Parameter register field positions
// ****************************************************************
`define ALR_CONT_BIT 7
`define ALR_RATE_MSB 6
`define ALR_RATE_LSB 4
`define ALR_OFFS_BIT 3
`define ALR_AVG_MSB 2
`define ALR_AVG_LSB 0
// ****************************************************************
// Reset values
// ****************************************************************
`define ALR_CONT_RST 1'h0
`define ALR_RATE_RST 3'h1
`define ALR_OFFS_RST 1'h1
`define ALR_AVG_RST 3'h5
// ****************************************************************
// Timing: clock rate and sample periods
// ****************************************************************
`define ALR_CLK_HZ 100000000
`define ALR_PERIOD_1 (`ALR_CLK_HZ / 1)
`define ALR_PERIOD_2 (`ALR_CLK_HZ / 2)
`define ALR_PERIOD_3 (`ALR_CLK_HZ / 3)
`define ALR_PERIOD_4 (`ALR_CLK_HZ / 4)
`define ALR_PERIOD_5 (`ALR_CLK_HZ / 5)
`define ALR_PERIOD_6 (`ALR_CLK_HZ / 6)
`define ALR_PERIOD_8 (`ALR_CLK_HZ / 8)
`endif

/* alr_averager.v */
// Accumulator that averages 2^n offset-corrected conversions
`timescale 1ns/10ps
`default_nettype none
module alr_averager (
  input wire i_clock,
  input wire i_rst,
  input wire i_start,
  input wire [2:0] i_avg_exp,
  input wire i_offs_en,
  input wire i_conv_valid,
  input wire [15:0] i_conv_data,
  input wire [15:0] i_offset,
  output reg o_done,
  output reg [15:0] o_result
);
  reg [22:0] acc_q;
  reg [7:0] cnt_q;
  reg busy_q;
  wire [15:0] corrected;
  wire [7:0] total;
  wire [22:0] acc_next;
  wire [22:0] acc_shift;

  // Offset subtracted before accumulation, clamped at zero
  assign corrected = (i_offs_en && (i_conv_data > i_offset)) ? i_conv_data - i_offset :
                     (i_offs_en ? 16'h0000 : i_conv_data);
  assign total = 8'h01 << i_avg_exp;
  assign acc_next = acc_q + {7'h00, corrected};
  assign acc_shift = acc_next >> i_avg_exp;

  // Count conversions and divide by shifting at the end
  always @(posedge i_clock) begin
    if (i_rst) begin
      acc_q <= 23'h000000;
      cnt_q <= 8'h00;
      busy_q <= 1'b0;
      o_done <= 1'b0;
      o_result <= 16'h0000;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        acc_q <= 23'h000000;
        cnt_q <= 8'h00;
        busy_q <= 1'b1;
      end else if (busy_q && i_conv_valid) begin
        if (cnt_q + 8'h01 == total) begin
          o_result <= acc_shift[15:0]; // Sum of 2^n 16-bit values fits 23 bits
          o_done <= 1'b1;
          busy_q <= 1'b0;
        end
        acc_q <= acc_next;
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* alr_regs.v */
// Ambient light parameter and result registers with measurement sequencer
`timescale 1ns/10ps
`default_nettype none
`include "alr_defines.vh"
module alr_regs (
  input wire i_clock,
  input wire i_rst,
  input wire i_wr_en,
  input wire i_rd_en,
  input wire [7:0] i_addr,
  input wire [7:0] i_wr_data,
  input wire i_self_timed_en,
  input wire i_light_on_demand_start,
  input wire i_conv_valid,
  input wire [15:0] i_conv_data,
  input wire i_offset_valid,
  input wire [15:0] i_offset_data,
  output reg [7:0] o_rd_data,
  output reg o_conv_req,
  output reg o_offset_req,
  output reg o_result_ready,
  output reg o_cont_mode
);
  // ****************************************************************
  // States, one-hot
  // ****************************************************************
  // Any other pattern falls back to idle
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_OFFS = 4'h2;
  localparam [3:0] ST_CONV = 4'h4;
  localparam [3:0] ST_WAIT = 4'h8;

  // Host register, working copy, result and sequencer state
  reg [7:0] params_q;
  reg [7:0] active_q;
  reg [15:0] result_q;
  reg [15:0] offset_q;
  reg [3:0] state_q;
  reg [26:0] timer_q;
  reg self_timed_q;
  reg od_q;
  // ****************************************************************
  // Sequencer and datapath handshakes
  // ****************************************************************
  wire avg_done;
  wire [15:0] avg_result;
  wire start_meas;
  wire cycle_go;
  wire avg_start;
  wire avg_conv_valid;

  // Sample period in clocks for a rate code
  // Counts are taken at full width, then cut to the 27-bit timer on purpose
  function [26:0] rate_period;
    input [2:0] code;
    reg [31:0] clocks;
    begin
      case (code)
        3'h0: clocks = `ALR_PERIOD_1;
        3'h1: clocks = `ALR_PERIOD_2;
        3'h2: clocks = `ALR_PERIOD_3;
        3'h3: clocks = `ALR_PERIOD_4;
        3'h4: clocks = `ALR_PERIOD_5;
        3'h5: clocks = `ALR_PERIOD_6;
        // Code 111 is undocumented; it and code 110 both take the fastest rate, a period of ALR_CLK_HZ / 8
        default: clocks = `ALR_PERIOD_8;
      endcase
      rate_period = clocks[26:0];
    end
  endfunction

  // ****************************************************************
  // Parameter register
  // ****************************************************************
  // Host writes; the rules are the host's to keep
  always @(posedge i_clock) begin
    if (i_rst) begin
      params_q <= {`ALR_CONT_RST, `ALR_RATE_RST, `ALR_OFFS_RST, `ALR_AVG_RST};
    end else if (i_wr_en && i_addr == `ALR_ADDR_PARAMS) begin
      params_q <= i_wr_data;
    end
  end

  // Working copy follows the register except while periodic mode runs
  // Freezing it keeps a running schedule from picking up half-changed settings
  always @(posedge i_clock) begin
    if (i_rst) begin
      active_q <= {`ALR_CONT_RST, `ALR_RATE_RST, `ALR_OFFS_RST, `ALR_AVG_RST};
      self_timed_q <= 1'b0;
      od_q <= 1'b0;
      o_cont_mode <= 1'b0;
    end else begin
      self_timed_q <= i_self_timed_en;
      od_q <= i_light_on_demand_start;
      if (!i_self_timed_en || !self_timed_q) begin
        active_q <= params_q;
      end
      o_cont_mode <= active_q[`ALR_CONT_BIT];
    end
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************
  // Results are read-only; unmapped addresses read zero
  // A read and a write of the parameter register in one cycle return the old value
  always @(posedge i_clock) begin
    if (i_rst) begin
      o_rd_data <= 8'h00;
    end else if (i_rd_en) begin
      case (i_addr)
        `ALR_ADDR_PARAMS: o_rd_data <= params_q;
        `ALR_ADDR_RES_HI: o_rd_data <= result_q[15:8];
        `ALR_ADDR_RES_LO: o_rd_data <= result_q[7:0];
        default: o_rd_data <= 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Measurement sequencer
  // ****************************************************************
  // On-demand start acts on its rising edge, so a level left high runs once
  assign start_meas = i_light_on_demand_start && !od_q && !i_self_timed_en;
  assign cycle_go = (state_q == ST_IDLE) && (start_meas ||
                    (i_self_timed_en && timer_q == 27'h0000000));

  // Offset, conversions, then wait out the sample period
  always @(posedge i_clock) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
      timer_q <= 27'h0000000;
      offset_q <= 16'h0000;
      result_q <= 16'h0000;
      o_conv_req <= 1'b0;
      o_offset_req <= 1'b0;
      o_result_ready <= 1'b0;
    end else begin
      o_offset_req <= 1'b0;
      o_result_ready <= 1'b0;
      // Periodic mode off clears the timer, so enabling it measures at once
      if (!i_self_timed_en) begin
        timer_q <= 27'h0000000;
      end else if (timer_q != 27'h0000000) begin
        timer_q <= timer_q - 27'h0000001;
      end
      case (state_q)
        ST_IDLE: begin
          if (cycle_go) begin
            timer_q <= rate_period(active_q[`ALR_RATE_MSB:`ALR_RATE_LSB]) - 27'h0000001;
            if (active_q[`ALR_OFFS_BIT]) begin
              o_offset_req <= 1'b1;
              state_q <= ST_OFFS;
            end else begin
              offset_q <= 16'h0000;
              o_conv_req <= 1'b1;
              state_q <= ST_CONV;
            end
          end
        end
        ST_OFFS: begin
          if (i_offset_valid) begin
            offset_q <= i_offset_data;
            o_conv_req <= 1'b1;
            state_q <= ST_CONV;
          end
        end
        ST_CONV: begin
          // Conversions after the last counted one are dropped by the averager
          if (avg_done) begin
            o_conv_req <= 1'b0;
            result_q <= avg_result;
            o_result_ready <= 1'b1;
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // With periodic mode on, continuous mode restarts at once, skipping the period wait
          if (active_q[`ALR_CONT_BIT]) begin
            timer_q <= 27'h0000000;
          end
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Averaging datapath
  // ****************************************************************
  // Restart on the cycle start and again once the offset sample is in
  assign avg_start = cycle_go || (state_q == ST_OFFS && i_offset_valid);
  // Only conversions taken while the sequencer wants them are counted
  assign avg_conv_valid = i_conv_valid && state_q == ST_CONV;
  alr_averager u_avg (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_start(avg_start),
    .i_avg_exp(active_q[`ALR_AVG_MSB:`ALR_AVG_LSB]),
    .i_offs_en(active_q[`ALR_OFFS_BIT]),
    .i_conv_valid(avg_conv_valid),
    .i_conv_data(i_conv_data),
    .i_offset(offset_q),
    .o_done(avg_done),
    .o_result(avg_result)
  );
endmodule
`default_nettype wire

/* alr_chk.sv */
// Checker for the ambient light parameter and result register block
`timescale 1ns/10ps
`default_nettype none
module alr_chk (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_self_timed_en,
  input wire logic i_light_on_demand_start,
  input wire logic i_conv_valid,
  input wire logic i_offset_valid,
  input wire logic [7:0] o_rd_data,
  input wire logic o_conv_req,
  input wire logic o_offset_req,
  input wire logic o_result_ready,
  input wire logic o_cont_mode
);
  // ****************************************************************
  // Shadow of the parameter register and conversion count
  // ****************************************************************
  logic [7:0] prm_q;
  logic [7:0] act_q;
  logic st_q;
  logic [7:0] cnt_q;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // Follow host writes and count conversions taken in one cycle
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      prm_q <= 8'h1D;
      act_q <= 8'h1D;
      st_q <= 1'b0;
      cnt_q <= 8'h00;
    end else begin
      if (i_wr_en && i_addr == 8'h84) prm_q <= i_wr_data;
      // Settings in use stay frozen while periodic mode keeps running
      st_q <= i_self_timed_en;
      if (!i_self_timed_en || !st_q) act_q <= prm_q;
      if (o_result_ready) cnt_q <= 8'h00;
      else if (i_conv_valid && o_conv_req) cnt_q <= cnt_q + 8'h01;
    end
  end
  // On-demand start while idle and periodic mode off
  sequence s_od_start;
    $rose(i_light_on_demand_start) && !i_self_timed_en && !o_conv_req && !o_offset_req;
  endsequence
  a_params_read: assert property (i_rd_en && i_addr == 8'h84 |=> o_rd_data == $past(prm_q))
    else $error("parameter readback wrong");
  a_unmapped_zero: assert property (
    i_rd_en && (i_addr < 8'h84 || i_addr > 8'h86) |=> o_rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_rd_hold: assert property (!i_rd_en |=> $stable(o_rd_data))
    else $error("read data changed without read");
  a_ready_pulse: assert property (o_result_ready |=> !o_result_ready)
    else $error("result ready longer than a cycle");
  a_ready_count: assert property (
    o_result_ready |-> $past(i_conv_valid, 2) && cnt_q == (8'h01 << act_q[2:0]))
    else $error("wrong number of conversions");
  a_offs_first: assert property (s_od_start ##0 act_q[3] |=> o_offset_req)
    else $error("no offset request after start");
  a_no_offs: assert property (!$past(act_q[3]) |-> !o_offset_req)
    else $error("offset requested while disabled");
  a_conv_after_offs: assert property (
    $rose(o_conv_req) && act_q[3] |-> $past(i_offset_valid))
    else $error("conversion before offset sample");
  a_cont_lag: assert property (o_cont_mode == $past(act_q[7]))
    else $error("continuous mode bit wrong");
endmodule
bind alr_regs alr_chk i_chk (.i_clock(i_clock), .i_rst(i_rst), .i_wr_en(i_wr_en),
  .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wr_data(i_wr_data),
  .i_self_timed_en(i_self_timed_en), .i_light_on_demand_start(i_light_on_demand_start),
  .i_conv_valid(i_conv_valid), .i_offset_valid(i_offset_valid), .o_rd_data(o_rd_data),
  .o_conv_req(o_conv_req), .o_offset_req(o_offset_req), .o_result_ready(o_result_ready),
  .o_cont_mode(o_cont_mode));
`default_nettype wire

/* alr_afe_model.sv */
// Behavioural light converter front end feeding offset and raw samples
`timescale 1ns/10ps
`default_nettype none
module alr_afe_model (
  input wire logic i_clock,
  input wire logic i_conv_req,
  input wire logic i_offset_req,
  input wire logic [15:0] i_base,
  input wire logic [15:0] i_offset,
  output logic o_conv_valid = 1'b0,
  output logic [15:0] o_conv_data = 16'h0000,
  output logic o_offset_valid = 1'b0,
  output logic [15:0] o_offset_data = 16'h0000
);
  logic [2:0] dly_q = 3'h0;
  logic [15:0] step_q = 16'h0000;
  // Offset answered late; conversions every other cycle, rising by 2; idle data toggles
  always @(posedge i_clock) begin
    dly_q <= i_offset_req ? 3'h3 : (dly_q != 3'h0 ? dly_q - 3'h1 : 3'h0);
    o_offset_valid <= (dly_q == 3'h1);
    o_offset_data <= (dly_q == 3'h1) ? i_offset : ~o_offset_data;
    o_conv_valid <= i_conv_req && !o_conv_valid;
    o_conv_data <= (i_conv_req && !o_conv_valid) ? i_base + step_q : ~o_conv_data;
    step_q <= !i_conv_req ? 16'h0000 : (!o_conv_valid ? step_q + 16'h0002 : step_q);
  end
endmodule
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the light parameter and result registers
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic i_clock = 1'b0, i_rst = 1'b1, i_wr_en = 1'b0, i_rd_en = 1'b0;
  logic i_self_timed_en = 1'b0, i_light_on_demand_start = 1'b0;
  logic i_conv_valid, i_offset_valid, o_conv_req, o_offset_req, o_result_ready, o_cont_mode;
  logic [7:0] i_addr = 8'h00, i_wr_data = 8'h00, o_rd_data;
  logic [15:0] i_conv_data, i_offset_data, base = 16'h0000, offv = 16'h0000;
  int n_errors = 0, compares = 0;
  always #5 i_clock = ~i_clock;
  alr_regs i_dut (.i_clock(i_clock), .i_rst(i_rst), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
    .i_addr(i_addr), .i_wr_data(i_wr_data), .i_self_timed_en(i_self_timed_en),
    .i_light_on_demand_start(i_light_on_demand_start), .i_conv_valid(i_conv_valid),
    .i_conv_data(i_conv_data), .i_offset_valid(i_offset_valid), .i_offset_data(i_offset_data),
    .o_rd_data(o_rd_data), .o_conv_req(o_conv_req), .o_offset_req(o_offset_req),
    .o_result_ready(o_result_ready), .o_cont_mode(o_cont_mode));
  alr_afe_model i_afe (.i_clock(i_clock), .i_conv_req(o_conv_req), .i_offset_req(o_offset_req),
    .i_base(base), .i_offset(offv), .o_conv_valid(i_conv_valid), .o_conv_data(i_conv_data),
    .o_offset_valid(i_offset_valid), .o_offset_data(i_offset_data));
  // ****************************************************************
  // Bus tasks and checks
  // ****************************************************************
  task tally_and_finish();
    if (n_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input bit ok, input string msg);
    compares++;
    if (!ok) begin
      n_errors++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_wr_en <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_clock);
    i_wr_en <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clock);
    i_rd_en <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd_en <= 1'b0;
    @(negedge i_clock);
    chk(o_rd_data === e, "read data mismatch");
  endtask
  // Poll for the result pulse at falling edges, up to a limit
  task wait_ready(input int lim, output int n);
    n = 0;
    while (o_result_ready !== 1'b1 && n < lim) begin
      @(negedge i_clock);
      n++;
    end
  endtask
  // One on-demand measurement, then the result read as two bytes
  task meas(input logic [7:0] p, input logic [15:0] b, input logic [15:0] o,
    input logic [15:0] e);
    int n;
    wr(8'h84, p);
    base <= b;
    offv <= o;
    @(posedge i_clock);
    i_light_on_demand_start <= 1'b1;
    wait_ready(3000, n);
    chk(n < 3000, "no result");
    @(posedge i_clock);
    i_light_on_demand_start <= 1'b0;
    rd(8'h85, e[15:8]);
    rd(8'h86, e[7:0]);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_reset();
    rd(8'h84, 8'h1D);
    rd(8'h85, 8'h00);
    rd(8'h86, 8'h00);
    rd(8'h87, 8'h00);
  endtask
  task t_regs();
    wr(8'h84, 8'hF2);
    rd(8'h84, 8'hF2);
    wr(8'h84, 8'h0A);
    rd(8'h84, 8'h0A);
    wr(8'h85, 8'hFF);
    rd(8'h85, 8'h00);
    wr(8'h86, 8'hFF);
    rd(8'h86, 8'h00);
  endtask
  task t_meas();
    meas(8'h0A, 16'h1234, 16'h0034, 16'h1203);
    meas(8'h01, 16'h1234, 16'h0000, 16'h1235);
    meas(8'h08, 16'h0010, 16'h0100, 16'h0000);
    meas(8'h07, 16'h0100, 16'h0000, 16'h017F);
  endtask
  // Periodic mode: a write made while it runs waits until the mode is cycled
  task t_periodic();
    int n;
    int k;
    wr(8'h84, 8'h18);
    base <= 16'h0200;
    offv <= 16'h0010;
    @(posedge i_clock);
    i_self_timed_en <= 1'b1;
    wr(8'h84, 8'h92);
    wait_ready(200, n);
    chk(n < 200, "no periodic result");
    k = 0;
    repeat (40) begin
      @(negedge i_clock);
      if (o_result_ready === 1'b1) k++;
    end
    chk(k == 0, "new setting used before mode cycled");
    rd(8'h85, 8'h01);
    rd(8'h86, 8'hF0);
    rd(8'h84, 8'h92);
    @(posedge i_clock);
    i_self_timed_en <= 1'b0;
    @(posedge i_clock);
    i_self_timed_en <= 1'b1;
    wait_ready(200, n);
    chk(n < 200, "no result after mode cycled");
    rd(8'h85, 8'h02);
    rd(8'h86, 8'h03);
    wait_ready(60, n);
    chk(n < 60, "continuous conversion did not repeat");
    @(posedge i_clock);
    i_self_timed_en <= 1'b0;
  endtask
  // Reset, run the scenarios, report
  initial begin
    repeat (5) @(posedge i_clock);
    i_rst <= 1'b0;
    t_reset();
    t_regs();
    t_meas();
    t_periodic();
    tally_and_finish();
  end
  // Watchdog against a hang
  initial begin
    #200000;
    n_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
